// ---- hdl/kbm_host_port.sv ----
// host mailbox port between system host and embedded keyboard controller
// assumes host cycles arrive already decoded to data/command port strobes
`timescale 1ns/1ns
`default_nettype none

module kbm_host_port
  import kbm_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // host side
  input wire logic i_host_wr,
  input wire logic i_host_rd,
  input wire logic i_host_addr_bit2,
  input wire logic [7:0] i_host_wdata,
  output logic [7:0] o_host_rdata,
  // controller output data stream
  input wire logic i_ctl_out_valid,
  input wire logic [7:0] i_ctl_out_data,
  output logic o_ctl_out_ready,
  // controller input data and status
  input wire logic i_ctl_in_rd,
  output logic [7:0] o_ctl_in_data,
  output logic [7:0] o_ctl_status,
  input wire logic i_ctl_status_wr,
  input wire logic [7:0] i_ctl_status_wdata,
  // controller ports and options
  input wire logic i_ctl_p1_wr,
  input wire logic [7:0] i_ctl_p1_data,
  input wire logic i_ctl_p2_wr,
  input wire logic [7:0] i_ctl_p2_data,
  input wire logic i_ctl_en_flags,
  input wire logic i_legacy_open_drain,
  output logic o_test_input_zero,
  output logic o_test_input_one,
  output logic [1:0] o_port1_in,
  // controller power and interrupts
  input wire logic i_ctl_halt,
  input wire logic i_ctl_stop,
  input wire logic i_ibf_int_en,
  input wire logic i_timer_ovf,
  input wire logic i_timer_irq_ack,
  output logic o_alu_clk_en,
  output logic o_osc_en,
  output logic o_wake,
  output logic o_wake_call,
  output logic [1:0] o_ctl_irq,
  // host interrupts and gate
  output logic o_kbd_interrupt_out,
  output logic o_mouse_interrupt_out,
  output logic o_gate_a20,
  // serial pins, open drain, enable low while driving
  input wire logic i_kbd_clock_pin,
  input wire logic i_kbd_data_pin,
  input wire logic i_mouse_clock_pin,
  input wire logic i_mouse_data_pin,
  output logic [3:0] o_serial_pin_out,
  output logic [3:0] o_serial_pin_oe_n,
  // legacy port one pins 7, 6, 2 (index 2, 1, 0)
  output logic [2:0] o_legacy_pin_out,
  output logic [2:0] o_legacy_pin_oe_n
);

  // ==========================================================================
  // state
  kbm_state_s s_q;
  kbm_state_s s_d;
  logic host_wr_data;
  logic host_wr_cmd;
  logic host_rd_data;
  logic fifo_push;
  logic fifo_pop;

  // host strobe decode: address bit 2 selects command/status port
  assign host_wr_data = i_host_wr & ~i_host_addr_bit2;
  assign host_wr_cmd = i_host_wr & i_host_addr_bit2;
  assign host_rd_data = i_host_rd & ~i_host_addr_bit2;

  // output buffer handshake: ready while a slot is free
  assign o_ctl_out_ready = (s_q.fifo_cnt != KBM_FIFO_DEPTH);
  assign fifo_push = i_ctl_out_valid & o_ctl_out_ready;
  assign fifo_pop = (s_q.fifo_cnt != 2'h0) & ~s_q.status[KBM_ST_OUTPUT_FULL];

  // ==========================================================================
  // next state
  always_comb begin
    s_d = s_q;
    s_d.wake = 1'b0;
    s_d.wake_call = 1'b0;

    // enable-flags option is sticky until reset
    if (i_ctl_en_flags) begin
      s_d.en_flags = 1'b1;
    end

    // host read: status has no side effect, data read frees output flag
    if (i_host_rd) begin
      if (i_host_addr_bit2) begin
        s_d.host_rdata = s_q.status;
      end else begin
        s_d.host_rdata = s_q.out_buf;
        s_d.status[KBM_ST_OUTPUT_FULL] = 1'b0;
      end
    end

    // controller status write touches user bits only
    if (i_ctl_status_wr) begin
      s_d.status = (s_q.status & ~KBM_ST_USER_MASK) | (i_ctl_status_wdata & KBM_ST_USER_MASK);
    end

    // controller read of input buffer clears input flag
    if (i_ctl_in_rd) begin
      s_d.status[KBM_ST_INPUT_FULL] = 1'b0;
    end

    // host write; a set in the same cycle as the clear wins
    if (i_host_wr) begin
      s_d.in_buf = i_host_wdata;
      s_d.status[KBM_ST_INPUT_FULL] = 1'b1;
      s_d.status[KBM_ST_CMD_DATA] = i_host_addr_bit2;
      if (host_wr_cmd) begin
        s_d.status[KBM_ST_CMD_DATA] = 1'b1;
      end
      if (host_wr_data) begin
        s_d.status[KBM_ST_CMD_DATA] = 1'b0;
      end
    end

    // two-entry output buffer
    if (fifo_push) begin
      s_d.fifo_mem[s_q.fifo_wp] = i_ctl_out_data;
      s_d.fifo_wp = ~s_q.fifo_wp;
    end
    if (fifo_pop) begin
      s_d.out_buf = s_q.fifo_mem[s_q.fifo_rp];
      s_d.status[KBM_ST_OUTPUT_FULL] = 1'b1;
      s_d.fifo_rp = ~s_q.fifo_rp;
    end
    s_d.fifo_cnt = s_q.fifo_cnt + {1'b0, fifo_push} - {1'b0, fifo_pop};

    // port writes
    if (i_ctl_p2_wr) begin
      s_d.p2 = i_ctl_p2_data;
    end
    if (i_ctl_p1_wr) begin
      s_d.p1 = i_ctl_p1_data;
    end

    // legacy pins: assist counter loads on a written one
    for (int i = 0; i < KBM_NUM_LEGACY; i++) begin
      if (s_q.assist_cnt[i] != 3'h0) begin
        s_d.assist_cnt[i] = s_q.assist_cnt[i] - 3'h1;
      end
      if (i_ctl_p1_wr) begin
        if (i_ctl_p1_data[KBM_LEGACY_BITS[i]] && !i_legacy_open_drain) begin
          s_d.assist_cnt[i] = KBM_ASSIST_CLKS;
        end else begin
          s_d.assist_cnt[i] = 3'h0;
        end
      end
    end

    // timer overflow flag, set wins over acknowledge
    if (i_timer_irq_ack) begin
      s_d.tmr_flag = 1'b0;
    end
    if (i_timer_ovf) begin
      s_d.tmr_flag = 1'b1;
    end

    // power modes: a host input write wakes the core
    unique case (s_q.pwr)
      KBM_PWR_RUN: begin
        if (i_ctl_stop) begin
          s_d.pwr = KBM_PWR_STOP;
        end else if (i_ctl_halt) begin
          s_d.pwr = KBM_PWR_HALT;
        end
      end
      KBM_PWR_HALT, KBM_PWR_STOP: begin
        if (i_host_wr) begin
          s_d.pwr = KBM_PWR_RUN;
          s_d.wake = 1'b1;
          s_d.wake_call = i_ibf_int_en;
        end
      end
      default: begin
        s_d.pwr = KBM_PWR_RUN;
      end
    endcase

    // host interrupts from next flag and port values
    if (s_d.en_flags) begin
      s_d.kbd_interrupt_out = s_d.p2[KBM_P2_KBD_IRQ] & s_d.status[KBM_ST_OUTPUT_FULL];
      s_d.mouse_interrupt_out = s_d.p2[KBM_P2_MOUSE_IRQ] & ~s_d.status[KBM_ST_INPUT_FULL];
    end else begin
      s_d.kbd_interrupt_out = s_d.p2[KBM_P2_KBD_IRQ];
      s_d.mouse_interrupt_out = s_d.p2[KBM_P2_MOUSE_IRQ];
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '0;
      s_q.pwr <= KBM_PWR_RUN;
      s_q.status <= KBM_STATUS_RST;
      s_q.p1 <= KBM_P1_RST;
      s_q.p2 <= KBM_P2_RST;
      s_q.kbd_interrupt_out <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // outputs
  // host and controller facing data
  assign o_host_rdata = s_q.host_rdata;
  assign o_ctl_in_data = s_q.in_buf;
  assign o_ctl_status = s_q.status;
  assign o_kbd_interrupt_out = s_q.kbd_interrupt_out;
  assign o_mouse_interrupt_out = s_q.mouse_interrupt_out;
  assign o_gate_a20 = s_q.p2[KBM_P2_GATE_A20];

  // power and the two controller interrupt sources
  assign o_alu_clk_en = (s_q.pwr == KBM_PWR_RUN);
  assign o_osc_en = (s_q.pwr != KBM_PWR_STOP);
  assign o_wake = s_q.wake;
  assign o_wake_call = s_q.wake_call;
  assign o_ctl_irq = {s_q.tmr_flag, s_q.status[KBM_ST_INPUT_FULL] & i_ibf_int_en};

  // serial pins: port bit high pulls pin low; order kbd_clock_pin, kbd_data_pin, mclk, mouse_data_pin
  assign o_serial_pin_out = 4'h0;
  assign o_serial_pin_oe_n = {~s_q.p2[KBM_P2_KBD_CLOCK], ~s_q.p2[KBM_P2_KBD_DATA],
                              ~s_q.p2[KBM_P2_MOUSE_CLOCK], ~s_q.p2[KBM_P2_MOUSE_DATA]};
  assign o_test_input_zero = i_kbd_clock_pin;
  assign o_test_input_one = i_mouse_clock_pin;
  assign o_port1_in = {i_mouse_data_pin, i_kbd_data_pin};

  // legacy pins: always outputs, never inverted
  for (genvar g = 0; g < KBM_NUM_LEGACY; g++) begin : g_legacy
    assign o_legacy_pin_out[g] = s_q.p1[KBM_LEGACY_BITS[g]];
    // open drain cuts a running assist short so a one never drives high
    assign o_legacy_pin_oe_n[g] = s_q.p1[KBM_LEGACY_BITS[g]] &
                                  ((s_q.assist_cnt[g] == 3'h0) | i_legacy_open_drain);
  end

endmodule

`default_nettype wire

// ---- include/kbm_pkg.sv ----
// constants, types and state layout of the keyboard host mailbox port
// assumes one 12 MHz controller clock and an active-high asynchronous reset
//
// Functional notes
// - data port write loads input, clears command flag
// - command port write loads input, sets command flag
// - data port read returns output buffer
// - host data read clears output full flag
// - status read has no side effects
// - controller output write loads buffer, sets flag
// - command flag copies host address bit two
// - enable flags: keyboard interrupt gated output-full
// - no enable flags: keyboard interrupt follows port bit
// - keyboard interrupt is zero after reset
// - enable flags: mouse interrupt gated inverted input-full
// - no enable flags: mouse interrupt follows port bit
// - port two bit one drives gate A20
// - legacy pins: one drives high six clocks
// - open drain legacy pins: one releases pin
// - legacy pins never input or inverted
// - four serial pins: inverted port bits, read back
// - controller input read clears input full flag
// - halt stops ALU clock, wakes on write
// - stop disables oscillator, wakes on write
// - exactly two controller interrupt sources
// - status clears on reset, controller writes user bits
// ==========================================================================
// package
package kbm_pkg;

  // host port offsets
  localparam logic [7:0] KBM_HOST_DATA_PORT_OFS = 8'h60;
  localparam logic [7:0] KBM_HOST_CMD_STATUS_PORT_OFS = 8'h64;

  // status register field positions
  localparam int KBM_ST_OUTPUT_FULL = 0;
  localparam int KBM_ST_INPUT_FULL = 1;
  localparam int KBM_ST_CMD_DATA = 3;
  localparam logic [7:0] KBM_ST_USER_MASK = 8'hf4;

  // controller port field positions
  localparam int KBM_P2_GATE_A20 = 1;
  localparam int KBM_P2_MOUSE_DATA = 2;
  localparam int KBM_P2_MOUSE_CLOCK = 3;
  localparam int KBM_P2_KBD_IRQ = 4;
  localparam int KBM_P2_MOUSE_IRQ = 5;
  localparam int KBM_P2_KBD_CLOCK = 6;
  localparam int KBM_P2_KBD_DATA = 7;
  localparam int KBM_NUM_LEGACY = 3;
  localparam logic [2:0][2:0] KBM_LEGACY_BITS = {3'h7, 3'h6, 3'h2};

  // reset values: serial pins held low, interrupt bits low
  localparam logic [7:0] KBM_STATUS_RST = 8'h00;
  localparam logic [7:0] KBM_P1_RST = 8'hff;
  localparam logic [7:0] KBM_P2_RST = 8'hce;

  // high-drive assist on legacy pins, counted in controller clocks
  localparam int KBM_ASSIST_TIME_NS = 500;
  localparam logic [2:0] KBM_ASSIST_CLKS = 3'h6;

  // output buffer depth
  localparam logic [1:0] KBM_FIFO_DEPTH = 2'h2;

  // power states
  typedef enum logic [1:0] {
    KBM_PWR_RUN = 2'b00,
    KBM_PWR_HALT = 2'b01,
    KBM_PWR_STOP = 2'b10
  } kbm_pwr_e;

  // whole block state
  typedef struct packed {
    kbm_pwr_e pwr;
    logic en_flags;
    logic [7:0] in_buf;
    logic [7:0] out_buf;
    logic [7:0] status;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [2:0][2:0] assist_cnt;
    logic [1:0][7:0] fifo_mem;
    logic fifo_wp;
    logic fifo_rp;
    logic [1:0] fifo_cnt;
    logic tmr_flag;
    logic kbd_interrupt_out;
    logic mouse_interrupt_out;
    logic [7:0] host_rdata;
    logic wake;
    logic wake_call;
  } kbm_state_s;

endpackage

// ---- dv/kbm_host_model.sv ----
// host model issuing one-cycle data and command port cycles
// assumes strobes are sampled on the rising clock edge
`timescale 1ns/1ns
`default_nettype none
module kbm_host_model (
  // clock
  input wire logic i_clk,
  // host strobes and data
  output logic o_wr = 1'b0,
  output logic o_rd = 1'b0,
  output logic o_a2 = 1'b0,
  output logic [7:0] o_wdata = 8'h00
);
  // ==========
  // host cycle: one strobe edge, then release
  task automatic cyc(input logic w, input logic a, input logic [7:0] d);
    @(posedge i_clk);
    o_wr <= w;
    o_rd <= !w;
    o_a2 <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    o_a2 <= !a;
    o_wdata <= ~d; // released bus shows no stale value
  endtask
endmodule
`default_nettype wire

// ---- dv/kbm_host_port_properties.sv ----
// timing checks on the keyboard host mailbox port
// assumes it is bound to kbm_host_port and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module kbm_host_port_properties (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // host side
  input wire logic i_host_wr,
  input wire logic i_host_rd,
  input wire logic i_host_addr_bit2,
  input wire logic [7:0] o_host_rdata,
  // controller side
  input wire logic [7:0] o_ctl_status,
  input wire logic i_ctl_in_rd,
  input wire logic i_ctl_en_flags,
  input wire logic i_ctl_p1_wr,
  input wire logic [7:0] i_ctl_p1_data,
  input wire logic i_ctl_p2_wr,
  input wire logic [7:0] i_ctl_p2_data,
  input wire logic i_legacy_open_drain,
  // pins and interrupts
  input wire logic o_kbd_interrupt_out,
  input wire logic o_mouse_interrupt_out,
  input wire logic [2:0] o_legacy_pin_out,
  input wire logic [2:0] o_legacy_pin_oe_n
);
  // ==========
  // flag mode tracker
  logic flags_on_q;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      flags_on_q <= 1'b0;
    end else if (i_ctl_en_flags) begin
      flags_on_q <= 1'b1;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ==========
  // properties
  property p_wr; i_host_wr |=> o_ctl_status[1] && o_ctl_status[3] == $past(i_host_addr_bit2); endproperty
  a_wr: assert property (p_wr) else $error("host write flags wrong");
  property p_rd; i_host_rd && !i_host_addr_bit2 |=> !o_ctl_status[0]; endproperty
  a_rd: assert property (p_rd) else $error("output full kept");
  property p_st; i_host_rd && i_host_addr_bit2 |=> o_host_rdata == $past(o_ctl_status); endproperty
  a_st: assert property (p_st) else $error("status read wrong");
  property p_in; i_ctl_in_rd && !i_host_wr |=> !o_ctl_status[1]; endproperty
  a_in: assert property (p_in) else $error("input full kept");
  property p_kp; !flags_on_q && !i_ctl_en_flags && i_ctl_p2_wr |=> o_kbd_interrupt_out == $past(i_ctl_p2_data[4]); endproperty
  a_kp: assert property (p_kp) else $error("kbd irq not port");
  property p_mp; !flags_on_q && !i_ctl_en_flags && i_ctl_p2_wr |=> o_mouse_interrupt_out == $past(i_ctl_p2_data[5]); endproperty
  a_mp: assert property (p_mp) else $error("mouse irq not port");
  property p_kf; flags_on_q && !o_ctl_status[0] |-> !o_kbd_interrupt_out; endproperty
  a_kf: assert property (p_kf) else $error("kbd irq without output full");
  property p_mf; flags_on_q && o_ctl_status[1] |-> !o_mouse_interrupt_out; endproperty
  a_mf: assert property (p_mf) else $error("mouse irq with input full");
  property p_as; i_ctl_p1_wr && i_ctl_p1_data[7] && !o_legacy_pin_out[2] && !i_legacy_open_drain
    |=> !o_legacy_pin_oe_n[2] [*6] ##1 o_legacy_pin_oe_n[2]; endproperty
  a_as: assert property (p_as) else $error("assist length wrong");
  property p_od; i_legacy_open_drain && $past(i_legacy_open_drain) |-> o_legacy_pin_oe_n == o_legacy_pin_out; endproperty
  a_od: assert property (p_od) else $error("open drain drive wrong");
  c_as: cover property (i_ctl_p1_wr && i_ctl_p1_data[7] && !i_legacy_open_drain);
  c_kf: cover property (flags_on_q && o_kbd_interrupt_out);
  c_st: cover property (i_host_rd && i_host_addr_bit2);
endmodule
bind kbm_host_port kbm_host_port_properties u_kbm_host_port_properties (.*);
`default_nettype wire

// ---- dv/tb_top.sv ----
// self-checking bench for the keyboard host mailbox port
// assumes the host model and the bound checker are compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // ==========
  // signals
  logic i_clk, i_rst, vld, od, ien, seen;
  logic [8:0] pw;
  logic osc;
  logic [7:0] odat, pd, rdat, idat, stat, d;
  logic [7:0] b[3];
  logic [1:0] p1in, cirq;
  logic rdy, t0, t1, aen, wk, wkc, kbd_interrupt_out, mouse_interrupt_out, a20;
  logic [3:0] soe;
  logic [2:0] lout, loe;
  wire logic hw, hr, ha;
  wire logic [7:0] hd;
  logic [31:0] lf = 32'hf5d3521c;
  logic [7:0] exp_q[$];
  int bad_count = 0, tests_run = 0, cyc_n = 0, n;
  // host model and design; released serial pins read high
  kbm_host_model u_host (.i_clk(i_clk), .o_wr(hw), .o_rd(hr), .o_a2(ha), .o_wdata(hd));
  kbm_host_port u_kbm_host_port (.i_clk(i_clk), .i_rst(i_rst), .i_host_wr(hw), .i_host_rd(hr),
    .i_host_addr_bit2(ha), .i_host_wdata(hd), .o_host_rdata(rdat), .i_ctl_out_valid(vld),
    .i_ctl_out_data(odat), .o_ctl_out_ready(rdy), .i_ctl_in_rd(pw[3]), .o_ctl_in_data(idat),
    .o_ctl_status(stat), .i_ctl_status_wr(pw[2]), .i_ctl_status_wdata(pd), .i_ctl_p1_wr(pw[0]),
    .i_ctl_p1_data(pd), .i_ctl_p2_wr(pw[1]), .i_ctl_p2_data(pd), .i_ctl_en_flags(pw[4]),
    .i_legacy_open_drain(od), .o_test_input_zero(t0), .o_test_input_one(t1), .o_port1_in(p1in),
    .i_ctl_halt(pw[5]), .i_ctl_stop(pw[7]), .i_ibf_int_en(ien), .i_timer_ovf(pw[6]),
    .i_timer_irq_ack(pw[8]), .o_alu_clk_en(aen), .o_osc_en(osc), .o_wake(wk), .o_wake_call(wkc),
    .o_ctl_irq(cirq), .o_kbd_interrupt_out(kbd_interrupt_out), .o_mouse_interrupt_out(mouse_interrupt_out), .o_gate_a20(a20),
    .i_kbd_clock_pin(soe[3]), .i_kbd_data_pin(soe[2]), .i_mouse_clock_pin(soe[1]),
    .i_mouse_data_pin(soe[0]), .o_serial_pin_out(), .o_serial_pin_oe_n(soe),
    .o_legacy_pin_out(lout), .o_legacy_pin_oe_n(loe));
  // ==========
  // helpers
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one-cycle controller strobe with data
  task automatic port(input int k, input logic [7:0] v);
    @(posedge i_clk);
    pw[k] <= 1'b1;
    pd <= v;
    @(posedge i_clk);
    pw[k] <= 1'b0;
    #1;
  endtask
  // output byte held until taken
  task automatic push(input logic [7:0] v);
    @(posedge i_clk);
    vld <= 1'b1;
    odat <= v;
    @(posedge i_clk);
    while (rdy !== 1'b1) @(posedge i_clk);
    vld <= 1'b0;
  endtask
  // host cycle; a read notes its expected byte
  task automatic host(input logic w, input logic a, input logic [7:0] v);
    if (!w) exp_q.push_back(v);
    u_host.cyc(w, a, v);
    #1;
  endtask
  task print_verdict;
    $display("counts run %0d bad %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ==========
  // clock, timeout and read monitor
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc_n++;
    if (cyc_n == 4000) begin
      bad_count++;
      print_verdict();
    end
  end
  always @(posedge i_clk) if (hr === 1'b1) begin
    #1;
    chk(rdat, exp_q.pop_front());
  end
  // ==========
  // scenarios
  initial begin
    {i_rst, vld, od, ien, pw, odat, pd} = {1'b1, 28'h0};
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    #1;
    chk({stat, kbd_interrupt_out, mouse_interrupt_out, a20, soe}, 15'h0010);
    port(2, 8'hff);
    chk(stat, 8'hf4);
    port(2, 8'h00);
    for (int a = 0; a < 2; a++) begin
      lf = nx(lf);
      host(1'b1, a[0], lf[7:0]);
      chk({stat[3:0], idat}, {a[0], 3'b010, lf[7:0]});
      port(3, 8'h00);
      chk(stat[1], 1'b0);
    end
    host(1'b0, 1'b1, 8'h08);
    $display("test mailbox done");
    for (int i = 3; i >= 0; i--) begin
      lf = nx(lf);
      d = {lf[7:6], i[1:0], lf[3:2], i[0], 1'b0};
      port(1, d);
      chk({kbd_interrupt_out, mouse_interrupt_out, a20}, {d[4], d[5], d[1]});
      chk({soe, t0, t1, p1in}, {~d[6], ~d[7], ~d[3], ~d[2], soe[3], soe[1], soe[0], soe[2]});
    end
    for (int k = 0; k < 3; k++) begin
      lf = nx(lf);
      b[k] = lf[7:0];
      push(b[k]);
    end
    repeat (3) @(posedge i_clk);
    #1;
    chk(rdy, 1'b0);
    for (int k = 0; k < 3; k++) host(1'b0, 1'b0, b[k]);
    chk(stat[0], 1'b0);
    $display("test stream done");
    port(4, 8'h00);
    port(1, 8'h30);
    chk(mouse_interrupt_out, 1'b1);
    push(8'h5a);
    repeat (2) @(posedge i_clk);
    #1;
    chk(kbd_interrupt_out, 1'b1);
    host(1'b0, 1'b0, 8'h5a);
    chk(kbd_interrupt_out, 1'b0);
    host(1'b1, 1'b0, 8'h11);
    chk(mouse_interrupt_out, 1'b0);
    port(3, 8'h00);
    chk(mouse_interrupt_out, 1'b1);
    $display("test flags done");
    port(0, 8'h00);
    port(0, 8'h80);
    n = 0;
    while (loe[2] === 1'b0 && n < 9) begin
      n++;
      @(posedge i_clk);
      #1;
    end
    chk(n[7:0], 8'h06);
    od <= 1'b1;
    port(0, 8'h00);
    chk(loe[2], 1'b0);
    port(0, 8'h80);
    chk({lout[2], loe[2]}, 2'b11);
    $display("test legacy done");
    ien <= 1'b1;
    port(5, 8'h00);
    chk(aen, 1'b0);
    seen = 1'b0;
    host(1'b1, 1'b1, 8'h22);
    repeat (2) begin
      seen = seen | (wk & wkc);
      @(posedge i_clk);
      #1;
    end
    chk({seen, aen}, 2'b11);
    port(6, 8'h00);
    chk(cirq, 2'b11);
    port(8, 8'h00);
    chk(cirq, 2'b01);
    port(7, 8'h00);
    chk({aen, osc}, 2'b00);
    host(1'b1, 1'b0, 8'h33);
    chk({aen, osc, stat[1]}, 3'b111);
    $display("test power done");
    print_verdict();
  end
endmodule
`default_nettype wire
